/* inc/dls_pkg.sv */
/*
  shared constants for the dummy load step sequencer: register map,
  field positions, reset values, timing counts and the state type.
  assumes a 100 MHz system clock and 32-bit AXI4-Lite data.
*/
`default_nettype none

package dls_pkg;

  // clock and the millisecond time base of the delay timers
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned CYC_PER_MS = (CLK_HZ / 1_000_000) * TICK_TIME_US;

  // scheme size and data widths
  localparam int unsigned MAX_STEPS = 5;
  localparam int unsigned STEP_W = 3;
  localparam int unsigned KW_W = 16;
  localparam int unsigned DLY_W = 16;
  localparam int unsigned AXI_AW = 8;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIP_KW = 8'h04;
  localparam logic [7:0] ADDR_RETURN_KW = 8'h08;
  localparam logic [7:0] ADDR_TRIP_DLY = 8'h0c;
  localparam logic [7:0] ADDR_RETURN_DLY = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_WORD_MASK = 8'hfc;

  // field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_NOUT_LSB = 4;
  localparam int unsigned STAT_OUT_LSB = 0;
  localparam int unsigned STAT_STEP_LSB = 8;
  localparam int unsigned STAT_MON_BIT = 16;
  localparam int unsigned STAT_BELOW_BIT = 17;
  localparam int unsigned STAT_ABOVE_BIT = 18;

  // reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [STEP_W-1:0] RST_NOUT = 3'h5;
  localparam logic [KW_W-1:0] RST_TRIP_KW = 16'h0028;
  localparam logic [KW_W-1:0] RST_RETURN_KW = 16'h0064;
  localparam logic [DLY_W-1:0] RST_TRIP_DLY = 16'h1388;
  localparam logic [DLY_W-1:0] RST_RETURN_DLY = 16'h1388;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    DLS_IDLE = 2'b01,
    DLS_MON = 2'b10
  } dls_state_t;

endpackage

`default_nettype wire

/* logic/dls_qual_timer.sv */
/*
  qualifying delay timer: counts whole milliseconds while active and
  gives a one-cycle done when the delay has run, then starts over.
  assumes active comes from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module dls_qual_timer
  import dls_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS,
  parameter int unsigned DW = DLY_W
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic active,
  input wire logic [DW-1:0] delay_ms,
  output logic done
);

  localparam int unsigned CW = (CYC_MS > 1) ? $clog2(CYC_MS) : 1;
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_MS - 1);

  logic [CW-1:0] cyc_q;
  logic [DW-1:0] ms_q;

  // done once the full delay has elapsed without a break; a delay lowered
  // below the running count fires at once instead of waiting for a wrap
  assign done = active && (ms_q >= delay_ms);

  // leaving the region clears the count, so no partial time carries
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !active || done)
    begin
      cyc_q <= '0;
      ms_q <= '0;
    end
    else if (cyc_q == CYC_LAST)
    begin
      cyc_q <= '0;
      ms_q <= ms_q + 1'b1;
    end
    else
    begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  property p_cancel;
    @(posedge aclk) disable iff (!aresetn)
    !active |=> (ms_q == '0) && (cyc_q == '0)
      && (!done || delay_ms == '0);
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("timer did not restart after leaving region");

  property p_ms_steps;
    @(posedge aclk) disable iff (!aresetn)
    active && !done && (cyc_q == CYC_LAST) |=> ms_q == $past(ms_q) + 1'b1;
  endproperty
  a_ms_steps: assert property (p_ms_steps)
    else $error("millisecond count did not advance");

endmodule

`default_nettype wire

/* logic/dls_sequencer.sv */
/*
  dummy load step sequencer with an AXI4-Lite register slave.
  assumes load_kw, gen_start, on_load and stopping come from logic on
  aclk; load_bank drives external load bank switching.
*/
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
// What this block does
// - drive up to five load bank steps, count set by software, when enabled
// - each generator start drops every load bank output
// - judge loading only once the generator is on load
// - loading below trip level starts the trip delay
// - trip delay served below level energises next unused step
// - keep repeating trip qualification until all configured steps are on
// - loading above return level starts the return delay
// - return delay served above level drops the highest energised step
// - keep removing one step per return delay until none remain
// - a stopping sequence drops all steps at once, with the open command
`timescale 1ns/100ps
`default_nettype none

module dls_sequencer
  import dls_pkg::*;
#(
  parameter int unsigned CYC_MS = CYC_PER_MS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [KW_W-1:0] load_kw,
  input wire logic gen_start,
  input wire logic on_load,
  input wire logic stopping,
  output logic [MAX_STEPS-1:0] load_bank
);

  // configuration
  logic enable_q;
  logic [STEP_W-1:0] nout_q;
  logic [KW_W-1:0] trip_kw_q;
  logic [KW_W-1:0] ret_kw_q;
  logic [DLY_W-1:0] trip_dly_q;
  logic [DLY_W-1:0] ret_dly_q;

  // sequencer state
  dls_state_t state_q;
  dls_state_t state_d;
  logic [STEP_W-1:0] step_q;
  logic [STEP_W-1:0] step_d;
  logic [MAX_STEPS-1:0] load_bank_q;
  logic below;
  logic above;
  logic trip_act;
  logic ret_act;
  logic trip_done;
  logic ret_done;

  // bus state
  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic wr_ok;
  logic [32:0] rd_view;

  // thermometer mask of the lowest n steps
  function automatic logic [MAX_STEPS-1:0] step_mask(
    input logic [STEP_W-1:0] n
  );
    logic [MAX_STEPS-1:0] m;
    m = '0;
    for (int i = 0; i < MAX_STEPS; i++)
    begin
      if (i < int'(n))
        m[i] = 1'b1;
    end
    return m;
  endfunction

  // byte lane merge for partial writes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // register read view; bit 32 flags a mapped address
  function automatic logic [32:0] reg_read(input logic [AXI_AW-1:0] a);
    logic [31:0] d;
    logic ok;
    logic [7:0] w;
    d = '0;
    ok = 1'b1;
    w = a & ADDR_WORD_MASK;
    if (w == ADDR_CTRL)
    begin
      d[CTRL_EN_BIT] = enable_q;
      d[CTRL_NOUT_LSB +: STEP_W] = nout_q;
    end
    else if (w == ADDR_TRIP_KW)
      d[KW_W-1:0] = trip_kw_q;
    else if (w == ADDR_RETURN_KW)
      d[KW_W-1:0] = ret_kw_q;
    else if (w == ADDR_TRIP_DLY)
      d[DLY_W-1:0] = trip_dly_q;
    else if (w == ADDR_RETURN_DLY)
      d[DLY_W-1:0] = ret_dly_q;
    else if (w == ADDR_STATUS)
    begin
      d[STAT_OUT_LSB +: MAX_STEPS] = load_bank_q;
      d[STAT_STEP_LSB +: STEP_W] = step_q;
      d[STAT_MON_BIT] = (state_q == DLS_MON);
      d[STAT_BELOW_BIT] = below;
      d[STAT_ABOVE_BIT] = above;
    end
    else
      ok = 1'b0;
    return {ok, d};
  endfunction

  // write address and data are taken in either order, one write at once
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // capture write address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_have_q <= 1'b0;
  end

  // capture write data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_have_q <= 1'b0;
  end

  // merged value of the word being written
  always_comb
  begin
    {wr_ok, wr_old} = reg_read(awaddr_q);
    wr_val = merge(wr_old, wdata_q, wstrb_q);
  end

  // read view of the requested address, top bit flags a mapped word
  always_comb
  begin
    rd_view = reg_read(s_axi_araddr);
  end

  // write response; status is read only, its writes are dropped quietly
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // configuration registers; step count clamps at the scheme maximum
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_q <= RST_ENABLE;
      nout_q <= RST_NOUT;
      trip_kw_q <= RST_TRIP_KW;
      ret_kw_q <= RST_RETURN_KW;
      trip_dly_q <= RST_TRIP_DLY;
      ret_dly_q <= RST_RETURN_DLY;
    end
    else if (wr_fire)
    begin
      if ((awaddr_q & ADDR_WORD_MASK) == ADDR_CTRL)
      begin
        enable_q <= wr_val[CTRL_EN_BIT];
        if (wr_val[CTRL_NOUT_LSB +: STEP_W] > STEP_W'(MAX_STEPS))
          nout_q <= STEP_W'(MAX_STEPS);
        else
          nout_q <= wr_val[CTRL_NOUT_LSB +: STEP_W];
      end
      else if ((awaddr_q & ADDR_WORD_MASK) == ADDR_TRIP_KW)
        trip_kw_q <= wr_val[KW_W-1:0];
      else if ((awaddr_q & ADDR_WORD_MASK) == ADDR_RETURN_KW)
        ret_kw_q <= wr_val[KW_W-1:0];
      else if ((awaddr_q & ADDR_WORD_MASK) == ADDR_TRIP_DLY)
        trip_dly_q <= wr_val[DLY_W-1:0];
      else if ((awaddr_q & ADDR_WORD_MASK) == ADDR_RETURN_DLY)
        ret_dly_q <= wr_val[DLY_W-1:0];
    end
  end

  // read channel, data registered with the valid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_view[31:0];
      rresp_q <= rd_view[32] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // region detection; a mis-set band may make both true, trip wins
  assign below = (load_kw < trip_kw_q);
  assign above = (load_kw > ret_kw_q);
  assign trip_act = (state_q == DLS_MON) && below && (step_q < nout_q);
  assign ret_act = (state_q == DLS_MON) && !below && above
    && (step_q != '0);

  dls_qual_timer #(
    .CYC_MS(CYC_MS),
    .DW(DLY_W)
  ) u_trip (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(trip_act),
    .delay_ms(trip_dly_q),
    .done(trip_done)
  );

  dls_qual_timer #(
    .CYC_MS(CYC_MS),
    .DW(DLY_W)
  ) u_ret (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(ret_act),
    .delay_ms(ret_dly_q),
    .done(ret_done)
  );

  // step sequencing; stop and start override any pending step
  always_comb
  begin
    state_d = state_q;
    step_d = step_q;
    case (state_q)
      DLS_IDLE:
      begin
        step_d = '0;
        if (enable_q && on_load && !stopping && !gen_start)
          state_d = DLS_MON;
      end
      DLS_MON:
      begin
        if (trip_done)
          step_d = step_q + 1'b1;
        else if (ret_done)
          step_d = step_q - 1'b1;
        else if (step_q > nout_q)
          step_d = nout_q;
        if (!on_load || !enable_q)
        begin
          state_d = DLS_IDLE;
          step_d = '0;
        end
      end
      default:
      begin
        state_d = DLS_IDLE;
        step_d = '0;
      end
    endcase
    if (stopping || gen_start)
    begin
      state_d = DLS_IDLE;
      step_d = '0;
    end
  end

  // state and step registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= DLS_IDLE;
      step_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      step_q <= step_d;
    end
  end

  // outputs follow the step count, so they move with it in one edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      load_bank_q <= '0;
    else
      load_bank_q <= step_mask(step_d) & step_mask(nout_q);
  end

  assign load_bank = load_bank_q;

  sequence s_trip_fire;
    (state_q == DLS_MON) && trip_done && on_load && enable_q
      && !stopping && !gen_start;
  endsequence

  sequence s_ret_fire;
    (state_q == DLS_MON) && ret_done && !trip_done && on_load
      && enable_q && !stopping && !gen_start;
  endsequence

  property p_max_steps;
    @(posedge aclk) disable iff (!aresetn)
    (step_q <= STEP_W'(MAX_STEPS)) && ((load_bank_q & ~step_mask(nout_q))
      == '0 || $changed(nout_q));
  endproperty
  a_max_steps: assert property (p_max_steps)
    else $error("output beyond configured step count");

  property p_start_clear;
    @(posedge aclk) disable iff (!aresetn)
    gen_start |=> (load_bank_q == '0) && (state_q == DLS_IDLE);
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("outputs not cleared on generator start");

  property p_off_load_hold;
    @(posedge aclk) disable iff (!aresetn)
    !on_load |=> (step_q == '0) && (load_bank_q == '0);
  endproperty
  a_off_load_hold: assert property (p_off_load_hold)
    else $error("steps active while off load");

  property p_trip_arms;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == DLS_MON) && (load_kw < trip_kw_q) && (step_q < nout_q)
      |-> trip_act;
  endproperty
  a_trip_arms: assert property (p_trip_arms)
    else $error("trip delay not running below trip level");

  property p_trip_step;
    @(posedge aclk) disable iff (!aresetn)
    s_trip_fire |=> (step_q == $past(step_q) + 1'b1)
      && load_bank_q[$past(step_q)];
  endproperty
  a_trip_step: assert property (p_trip_step)
    else $error("trip expiry did not add the next step");

  property p_ret_arms;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == DLS_MON) && (load_kw > ret_kw_q) && (load_kw >= trip_kw_q)
      && (step_q != '0) |-> ret_act;
  endproperty
  a_ret_arms: assert property (p_ret_arms)
    else $error("return delay not running above return level");

  property p_ret_step;
    @(posedge aclk) disable iff (!aresetn)
    s_ret_fire |=> (step_q == $past(step_q) - 1'b1)
      && !load_bank_q[step_q];
  endproperty
  a_ret_step: assert property (p_ret_step)
    else $error("return expiry did not drop the highest step");

  property p_stop_clear;
    @(posedge aclk) disable iff (!aresetn)
    stopping |=> (load_bank_q == '0) ##1 (load_bank_q == '0 || !stopping);
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("outputs not dropped on stopping sequence");

  property p_no_stray_step;
    @(posedge aclk) disable iff (!aresetn)
    !trip_done && !ret_done && (step_q <= nout_q) |=> step_q <= $past(step_q);
  endproperty
  a_no_stray_step: assert property (p_no_stray_step)
    else $error("step changed without an expired delay");

endmodule

`default_nettype wire

/* testbench/dls_load_model.sv */
/*
  behavioural far side of the sequencer: generator load measurement with
  the external load banks switched in by load_bank.
  assumes site_kw and step_kw are set by the bench on aclk edges.
*/
`timescale 1ns/100ps
`default_nettype none

module dls_load_model
  import dls_pkg::*;
(
  input wire logic [KW_W-1:0] site_kw,
  input wire logic [KW_W-1:0] step_kw,
  input wire logic [MAX_STEPS-1:0] bank,
  output logic [KW_W-1:0] load_kw
);
  // each energised bank adds the same step_kw at once; no settling delay is
  // modelled, so the sequencer sees the new load on the next edge
  always_comb
  begin
    load_kw = site_kw + KW_W'(step_kw * KW_W'($countones(bank)));
  end
endmodule

`default_nettype wire

/* testbench/dls_sequencer_tb_top.sv */
/*
  self-checking bench for the dummy load step sequencer.
  assumes the load model file and the design files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module dls_sequencer_tb_top
  import dls_pkg::*;
;
  localparam int unsigned CYC = 4;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, gen_start, on_load, stopping;
  logic [7:0] awaddr, araddr, rnd;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [KW_W-1:0] load_kw, site, stp;
  logic [MAX_STEPS-1:0] load_bank, lb;
  logic [33:0] qbus[$];
  logic [4:0] qb[$];
  int err_total, checks_done;

  dls_sequencer #(.CYC_MS(CYC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .load_kw(load_kw),
    .gen_start(gen_start), .on_load(on_load), .stopping(stopping),
    .load_bank(load_bank));

  dls_load_model model (.site_kw(site), .step_kw(stp), .bank(load_bank),
    .load_kw(load_kw));

  // free-running 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // one bus transfer, write or read; holds each channel until taken and
  // samples the handshake at the falling edge so no edge race can arise
  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [33:0] e);
    logic pa, pw, pr, ta, tw, tr;
    int n;
    pa = 1'b1;
    pw = w;
    pr = 1'b1;
    n = 0;
    qbus.push_back(e);
    if (w)
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    else
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while ((pa || pw || pr) && n < 100)
    begin
      @(negedge aclk);
      ta = w ? (awvalid && awready) : (arvalid && arready);
      tw = wvalid && wready;
      tr = w ? bvalid : rvalid;
      n++;
      @(posedge aclk);
      if (ta)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (tw)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (tr)
      begin
        pr = 1'b0;
        bready <= 1'b0;
        rready <= 1'b0;
      end
    end
    chk(34'(n < 100), 34'h1);
    // one idle edge keeps back to back calls from driving a signal twice
    @(posedge aclk);
  endtask

  // note the next bank pattern and time its arrival in cycles
  task automatic wb(input logic [4:0] e, input int lo, input int hi);
    int n;
    n = 0;
    qb.push_back(e);
    while (load_bank !== e && n < 500)
    begin
      @(negedge aclk);
      n++;
    end
    chk(34'(n >= lo && n <= hi), 34'h1);
    @(posedge aclk);
  endtask

  // result watcher: bus answers and every change of the bank outputs
  always @(negedge aclk)
  begin
    if (bvalid && bready)
      chk({bresp, 32'h0}, qbus.pop_front());
    if (rvalid && rready)
      chk({rresp, rdata}, qbus.pop_front());
    if (aresetn && load_bank !== lb)
    begin
      lb = load_bank;
      chk({29'h0, load_bank}, qb.size() > 0 ? {29'h0, qb.pop_front()} : 34'bx);
    end
  end

  // watchdog, well beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    results();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {gen_start, on_load, stopping, aresetn} = 4'h0;
    {awaddr, araddr, wdata, lb} = 53'h0;
    wstrb = 4'hf;
    site = 16'h003c;
    stp = 16'h0005;
    rnd = 8'h3c;
    err_total = 0;
    checks_done = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // look between edges so the check never races the first update
    @(negedge aclk);
    chk({29'h0, load_bank}, 34'h0);
    @(posedge aclk);
    // defaults, unmapped place and read-only status
    xf(1'b0, ADDR_CTRL, 32'h0, {RESP_OKAY, 32'h00000050});
    xf(1'b0, ADDR_TRIP_KW, 32'h0, {RESP_OKAY, 32'h00000028});
    xf(1'b0, ADDR_RETURN_KW, 32'h0, {RESP_OKAY, 32'h00000064});
    xf(1'b0, ADDR_TRIP_DLY, 32'h0, {RESP_OKAY, 32'h00001388});
    xf(1'b0, ADDR_RETURN_DLY, 32'h0, {RESP_OKAY, 32'h00001388});
    xf(1'b0, 8'h18, 32'h0, {RESP_SLVERR, 32'h0});
    xf(1'b1, 8'h18, 32'h1, {RESP_SLVERR, 32'h0});
    xf(1'b1, ADDR_STATUS, 32'hffffffff, {RESP_OKAY, 32'h0});
    xf(1'b0, ADDR_STATUS, 32'h0, {RESP_OKAY, 32'h0});
    // trip kept below return so the two regions never overlap
    xf(1'b1, ADDR_TRIP_KW, 32'h00000028, {RESP_OKAY, 32'h0});
    xf(1'b1, ADDR_TRIP_DLY, 32'h00000002, {RESP_OKAY, 32'h0});
    xf(1'b1, ADDR_RETURN_DLY, 32'h00000001, {RESP_OKAY, 32'h0});
    xf(1'b1, ADDR_CTRL, 32'h00000031, {RESP_OKAY, 32'h0});
    // low load while off load must not add any step
    site <= 16'h0000;
    repeat (40) @(posedge aclk);
    xf(1'b0, ADDR_STATUS, 32'h0, {RESP_OKAY, 32'h00020000});
    site <= 16'h003c;
    on_load <= 1'b1;
    repeat (5) @(posedge aclk);
    // short dips below trip, broken by random in-band load, never qualify
    repeat (10)
    begin
      site <= 16'h0000;
      repeat (5) @(posedge aclk);
      rnd = lf(rnd);
      site <= 16'h0028 + {8'h00, rnd} % 16'h003d;
      repeat (3) @(posedge aclk);
    end
    site <= 16'h0000;
    wb(5'h01, 8, 12);
    wb(5'h03, 6, 12);
    wb(5'h07, 6, 12);
    repeat (40) @(posedge aclk);
    xf(1'b0, ADDR_STATUS, 32'h0, {RESP_OKAY, 32'h00030307});
    // heavy load removes the highest step first, one per delay
    site <= 16'h00c8;
    wb(5'h03, 2, 8);
    wb(5'h01, 2, 8);
    wb(5'h00, 2, 8);
    repeat (30) @(posedge aclk);
    // too many outputs clamps to five, then fill the whole scheme
    xf(1'b1, ADDR_CTRL, 32'h00000071, {RESP_OKAY, 32'h0});
    xf(1'b0, ADDR_CTRL, 32'h0, {RESP_OKAY, 32'h00000051});
    site <= 16'h0000;
    wb(5'h01, 6, 12);
    wb(5'h03, 6, 12);
    wb(5'h07, 6, 12);
    wb(5'h0f, 6, 12);
    wb(5'h1f, 6, 12);
    // a stop drops every output at the edge that sees it
    stopping <= 1'b1;
    wb(5'h00, 1, 2);
    repeat (20) @(posedge aclk);
    stopping <= 1'b0;
    wb(5'h01, 6, 14);
    // a fresh start of the set drops the outputs as well
    gen_start <= 1'b1;
    @(posedge aclk);
    gen_start <= 1'b0;
    wb(5'h00, 0, 2);
    site <= 16'h003c;
    repeat (20) @(posedge aclk);
    results();
  end
endmodule

`default_nettype wire
